// ==== rtl/ttc_pkg.sv ====
// Purpose: Constants, register map and carrier types for the three timer/counter unit
// Assumes: 8-bit register bus, one oscillator clock
// Notes:   Offsets are the printed register addresses
package ttc_pkg;
	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [11:0] TTC_OFF_CTRL01   = 12'h410;
	localparam logic [11:0] TTC_OFF_EXTSTAT  = 12'h411;
	localparam logic [11:0] TTC_OFF_T2CTRL   = 12'h418;
	localparam logic [11:0] TTC_OFF_T2MODE   = 12'h419;
	localparam logic [11:0] TTC_OFF_SYSCFG   = 12'h440;
	localparam logic [11:0] TTC_OFF_T0L      = 12'h450;
	localparam logic [11:0] TTC_OFF_T0H      = 12'h451;
	localparam logic [11:0] TTC_OFF_T1L      = 12'h452;
	localparam logic [11:0] TTC_OFF_T1H      = 12'h453;
	localparam logic [11:0] TTC_OFF_RL0L     = 12'h454;
	localparam logic [11:0] TTC_OFF_RL0H     = 12'h455;
	localparam logic [11:0] TTC_OFF_RL1L     = 12'h456;
	localparam logic [11:0] TTC_OFF_RL1H     = 12'h457;
	localparam logic [11:0] TTC_OFF_T2L      = 12'h458;
	localparam logic [11:0] TTC_OFF_T2H      = 12'h459;
	localparam logic [11:0] TTC_OFF_CAPL     = 12'h45A;
	localparam logic [11:0] TTC_OFF_CAPH     = 12'h45B;
	localparam logic [11:0] TTC_OFF_MODE01   = 12'h45C;
	// Bit address window of bit-addressable registers
	localparam logic [11:0] TTC_BIT_CTRL01   = 12'h280;
	localparam logic [11:0] TTC_BIT_EXTSTAT  = 12'h288;
	localparam logic [11:0] TTC_BIT_T2CTRL   = 12'h2C0;
	localparam logic [11:0] TTC_BIT_T2MODE   = 12'h2C8;
	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int TTC_CTRL_TF1 = 7;
	localparam int TTC_CTRL_TR1 = 6;
	localparam int TTC_CTRL_TF0 = 5;
	localparam int TTC_CTRL_TR0 = 4;
	localparam int TTC_EXT_T1OE = 2;
	localparam int TTC_EXT_T0_OUTPUT_ENABLE = 0;
	localparam int TTC_T2C_TF2  = 7;
	localparam int TTC_T2C_TR2  = 2;
	localparam int TTC_T2C_CT   = 1;
	localparam int TTC_T2M_UPDOWN_COUNT_ENABLE = 0;
	localparam logic [7:0] TTC_RST_BYTE     = 8'h00;
	localparam logic [7:0] TTC_EXT_MASK     = 8'h05;
	localparam logic [7:0] TTC_T2MODE_MASK  = 8'h33;
	localparam logic [7:0] TTC_SYSCFG_MASK  = 8'h0F;
	// Prescale divisors selected by the two-bit field
	localparam logic [6:0] TTC_DIV_4  = 7'h04;
	localparam logic [6:0] TTC_DIV_16 = 7'h10;
	localparam logic [6:0] TTC_DIV_64 = 7'h40;
	// Phase of the 2-cycle sample toggle on which pins are sampled
	localparam logic       TTC_SAMPLE_EVERY_2 = 1'b1;
	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [3:0] {
		TTC_M0_RELOAD16 = 4'h1,
		TTC_M1_COUNT16  = 4'h2,
		TTC_M2_RELOAD8  = 4'h4,
		TTC_M3_SPLIT    = 4'h8
	} ttc_mode_t;
	typedef struct packed {
		logic       gate;
		logic       counter_sel;
		logic [1:0] mode;
	} ttc_modegrp_t;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        bit_op;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} ttc_bus_req_t;
	// Turns the mode field into its one-hot state
	function automatic ttc_mode_t ttc_decode_mode(input logic [1:0] m);
		case (m)
			2'd0: return TTC_M0_RELOAD16;
			2'd1: return TTC_M1_COUNT16;
			2'd2: return TTC_M2_RELOAD8;
			default: return TTC_M3_SPLIT;
		endcase
	endfunction : ttc_decode_mode
endpackage : ttc_pkg

// ==== rtl/ttc_unit.sv ====
// Purpose: Three 16-bit timer/counters with shared prescaled tick and 8-bit register port
// Assumes: sys_clk_in is the oscillator; pins are asynchronous
// Notes:   Watchdog, serial ports, Timer 2 capture/baud logic sit elsewhere
// Overview of operation
// (RULE1) Two 16-bit up timers and a third 16-bit up/down timer.
// (RULE2) Each timer selects tick or external pin by its own select bit.
// (RULE3) Timers count up unless stated; counts readable anytime.
// (RULE4) Tick is oscillator divided by 4, 16 or 64 via prescale field.
// (RULE5) One prescale setting serves all timers and watchdog.
// (RULE6) Counter mode counts each falling edge on the timer's pin.
// (RULE7) Pins sampled every 2 oscillator cycles; detection within 4.
// (RULE8) Counter mode supports events up to one quarter oscillator rate.
// (RULE9) Pin source holds each level at least 2 oscillator cycles.
// (RULE10) Timers 0 and 1 have four modes from two-bit fields.
// (RULE11) Mode 0 is 16-bit auto-reload.
// (RULE12) Mode register holds gate, select, two mode bits per timer.
// (RULE13) Control register: overflow and run bits, external interrupt flags, reset 00.
// (RULE14) Extended status: timer 1 output enable bit 2, timer 0 bit 0.
// (RULE15) Timer 2 control holds flags, clock selects, enable, run, select.
// (RULE16) Timer 2 mode holds clock selects, output enable, up/down enable.
// (RULE17) Timer 2 capture register split high/low bytes, reset zero.
// (RULE18) Byte bus: wide write stores low byte, wide read upper undefined.
// (RULE19) Unimplemented bits reset to 0; software writes zeros.
// (RULE20) Control and status registers support single-bit access.
// (RULE21) Mode 0 high overflow sets flag and reloads both bytes.
// (RULE22) Mode 2 low byte overflows, sets flag, reloads low byte only.
// (RULE23) Mode 3: timer 1 holds, timer 0 splits; high half uses timer 1 bits.
module ttc_unit
	import ttc_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	// Register port
	input  wire ttc_bus_req_t bus_req_in,
	output logic [15:0]      bus_rdata_out,
	// External pins
	input  wire logic [2:0]  ext_count_in,
	input  wire logic [1:0]  ext_int_in,
	// Status to the core
	output logic             tick_out,
	output logic [2:0]       overflow_out
);
	// ************************************************************
	// Pin synchronisers and sampling
	// ************************************************************
	logic [2:0] pin_s1_r, pin_s2_r, pin_smp_r;
	logic [1:0] int_s1_r, int_s2_r, int_prev_r;
	logic       phase_r;
	logic [2:0] pin_fall;
	logic [1:0] int_fall;
	// Two flops before anything looks at a pin
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_s1_r <= 3'h7;
			pin_s2_r <= 3'h7;
			int_s1_r <= 2'h3;
			int_s2_r <= 2'h3;
		end else begin
			pin_s1_r <= ext_count_in;
			pin_s2_r <= pin_s1_r;
			int_s1_r <= ext_int_in;
			int_s2_r <= int_s1_r;
		end
	end
	// Sample every second cycle; a 2-cycle level is always caught
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			phase_r   <= 1'b0;
			pin_smp_r <= 3'h7;
			int_prev_r <= 2'h3;
		end else begin
			phase_r <= ~phase_r;
			if (phase_r == TTC_SAMPLE_EVERY_2)
				pin_smp_r <= pin_s2_r; // RULE7 RULE9
			int_prev_r <= int_s2_r;
		end
	end
	assign pin_fall = {3{phase_r}} & pin_smp_r & ~pin_s2_r; // RULE6 RULE8
	assign int_fall = int_prev_r & ~int_s2_r;
	// ************************************************************
	// Registers
	// ************************************************************
	logic [7:0] ctrl01_r, extstat_r, t2ctrl_r, t2mode_r, syscfg_r, mode01_r;
	logic [7:0] t0l_r, t0h_r, t1l_r, t1h_r, t2l_r, t2h_r, capl_r, caph_r;
	logic [7:0] rl0l_r, rl0h_r, rl1l_r, rl1h_r;
	logic [6:0] pre_cnt_r;
	logic       tick;
	ttc_modegrp_t grp0, grp1;
	ttc_mode_t    mode0, mode1;
	assign grp0  = mode01_r[3:0]; // RULE12
	assign grp1  = mode01_r[7:4];
	assign mode0 = ttc_decode_mode(grp0.mode); // RULE10
	assign mode1 = ttc_decode_mode(grp1.mode);
	// Full-byte write strobe for one address
	function automatic logic wr_hit(input ttc_bus_req_t r, input logic [11:0] a);
		return r.wr && !r.bit_op && (r.addr == a);
	endfunction : wr_hit
	// Merge a bit write into a byte when the bit address falls in its window
	function automatic logic [7:0] bit_merge(input ttc_bus_req_t r, input logic [11:0] base,
		input logic [7:0] cur, output logic hit);
		logic [7:0] v;
		v = cur;
		hit = r.wr && r.bit_op && (r.addr[11:3] == base[11:3]);
		if (hit)
			v[r.addr[2:0]] = r.wdata[0];
		return v;
	endfunction : bit_merge
	// ************************************************************
	// Prescaler: single shared divider
	// ************************************************************
	logic [6:0] div_sel;
	always_comb begin
		case (syscfg_r[3:2]) // RULE4
			2'd1:    div_sel = TTC_DIV_16;
			2'd2:    div_sel = TTC_DIV_64;
			default: div_sel = TTC_DIV_4;
		endcase
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in)
			pre_cnt_r <= 7'h00;
		else if (pre_cnt_r >= div_sel - 7'h01)
			pre_cnt_r <= 7'h00;
		else
			pre_cnt_r <= pre_cnt_r + 7'h01;
	end
	assign tick = (pre_cnt_r >= div_sel - 7'h01); // RULE5
	assign tick_out = tick;
	// ************************************************************
	// Count enables
	// ************************************************************
	logic inc0, inc1, inc0h, inc2;
	logic run0, run1;
	assign run0 = ctrl01_r[TTC_CTRL_TR0] && (!grp0.gate || int_s2_r[0]);
	assign run1 = ctrl01_r[TTC_CTRL_TR1] && (!grp1.gate || int_s2_r[1]);
	assign inc0  = run0 && (grp0.counter_sel ? pin_fall[0] : tick); // RULE2
	assign inc1  = run1 && (mode1 != TTC_M3_SPLIT) && (grp1.counter_sel ? pin_fall[1] : tick); // RULE23
	assign inc0h = ctrl01_r[TTC_CTRL_TR1] && tick; // RULE23
	assign inc2  = t2ctrl_r[TTC_T2C_TR2] && (t2ctrl_r[TTC_T2C_CT] ? pin_fall[2] : tick);
	// ************************************************************
	// Timer 0/1 next counts
	// ************************************************************
	logic [7:0] n0l, n0h, n1l, n1h;
	logic       ovf0, ovf1, ovf0h;
	always_comb begin
		n0l = t0l_r; n0h = t0h_r; ovf0 = 1'b0; ovf0h = 1'b0;
		if (inc0) begin
			case (mode0)
				TTC_M0_RELOAD16: begin
					{n0h, n0l} = {t0h_r, t0l_r} + 16'h0001; // RULE3
					if ({t0h_r, t0l_r} == 16'hFFFF) begin
						ovf0 = 1'b1;
						{n0h, n0l} = {rl0h_r, rl0l_r}; // RULE11 RULE21
					end
				end
				TTC_M1_COUNT16: begin
					{n0h, n0l} = {t0h_r, t0l_r} + 16'h0001;
					ovf0 = ({t0h_r, t0l_r} == 16'hFFFF);
				end
				TTC_M2_RELOAD8: begin
					n0l = (t0l_r == 8'hFF) ? rl0l_r : t0l_r + 8'h01; // RULE22
					ovf0 = (t0l_r == 8'hFF);
				end
				default: begin
					n0l = t0l_r + 8'h01;
					ovf0 = (t0l_r == 8'hFF);
				end
			endcase
		end
		if (mode0 == TTC_M3_SPLIT && inc0h) begin
			n0h = t0h_r + 8'h01; // RULE23
			ovf0h = (t0h_r == 8'hFF);
		end
	end
	always_comb begin
		n1l = t1l_r; n1h = t1h_r; ovf1 = 1'b0;
		if (inc1) begin
			case (mode1)
				TTC_M0_RELOAD16: begin
					{n1h, n1l} = {t1h_r, t1l_r} + 16'h0001;
					if ({t1h_r, t1l_r} == 16'hFFFF) begin
						ovf1 = 1'b1;
						{n1h, n1l} = {rl1h_r, rl1l_r}; // RULE21
					end
				end
				TTC_M2_RELOAD8: begin
					n1l = (t1l_r == 8'hFF) ? rl1l_r : t1l_r + 8'h01; // RULE22
					ovf1 = (t1l_r == 8'hFF);
				end
				default: begin
					{n1h, n1l} = {t1h_r, t1l_r} + 16'h0001;
					ovf1 = ({t1h_r, t1l_r} == 16'hFFFF);
				end
			endcase
		end
	end
	// Timer 2: up, or down when up/down enable is set and the direction pin is low
	logic [15:0] n2;
	logic        ovf2, down2;
	assign down2 = t2mode_r[TTC_T2M_UPDOWN_COUNT_ENABLE] && !int_s2_r[1];
	always_comb begin
		n2 = {t2h_r, t2l_r}; ovf2 = 1'b0;
		if (inc2) begin
			if (down2) begin
				n2 = {t2h_r, t2l_r} - 16'h0001; // RULE1
				ovf2 = ({t2h_r, t2l_r} == 16'h0000);
			end else begin
				n2 = {t2h_r, t2l_r} + 16'h0001;
				ovf2 = ({t2h_r, t2l_r} == 16'hFFFF);
			end
		end
	end
	// ************************************************************
	// Flag events; an overflow wins over a clear in the same cycle
	// ************************************************************
	logic set_tf0, set_tf1, set_ie0, set_ie1;
	assign set_tf0 = ovf0 && !extstat_r[TTC_EXT_T0_OUTPUT_ENABLE];
	assign set_tf1 = (mode0 == TTC_M3_SPLIT ? ovf0h : ovf1) && !extstat_r[TTC_EXT_T1OE]; // RULE23
	assign set_ie0 = ctrl01_r[0] ? int_fall[0] : !int_s2_r[0];
	assign set_ie1 = ctrl01_r[2] ? int_fall[1] : !int_s2_r[1];
	logic [7:0] ctrl_w, ext_w, t2c_w, t2m_w;
	logic       hc, he, h2c, h2m;
	always_comb begin
		ctrl_w = bit_merge(bus_req_in, TTC_BIT_CTRL01, ctrl01_r, hc); // RULE20
		ext_w  = bit_merge(bus_req_in, TTC_BIT_EXTSTAT, extstat_r, he);
		t2c_w  = bit_merge(bus_req_in, TTC_BIT_T2CTRL, t2ctrl_r, h2c);
		t2m_w  = bit_merge(bus_req_in, TTC_BIT_T2MODE, t2mode_r, h2m);
		if (wr_hit(bus_req_in, TTC_OFF_CTRL01))  ctrl_w = bus_req_in.wdata; // RULE18
		if (wr_hit(bus_req_in, TTC_OFF_EXTSTAT)) ext_w  = bus_req_in.wdata;
		if (wr_hit(bus_req_in, TTC_OFF_T2CTRL))  t2c_w  = bus_req_in.wdata;
		if (wr_hit(bus_req_in, TTC_OFF_T2MODE))  t2m_w  = bus_req_in.wdata;
	end
	// Control and status registers
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl01_r  <= TTC_RST_BYTE; // RULE13
			extstat_r <= TTC_RST_BYTE;
			t2ctrl_r  <= TTC_RST_BYTE;
			t2mode_r  <= TTC_RST_BYTE;
		end else begin
			ctrl01_r <= ctrl_w | {set_tf1, 1'b0, set_tf0, 1'b0, set_ie1, 1'b0, set_ie0, 1'b0}; // RULE13
			extstat_r <= ext_w & TTC_EXT_MASK; // RULE14 RULE19
			t2ctrl_r  <= t2c_w | {ovf2 && !t2mode_r[1], 7'h00}; // RULE15
			t2mode_r  <= t2m_w & TTC_T2MODE_MASK; // RULE16 RULE19
		end
	end
	// Configuration, reload and capture bytes
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			syscfg_r <= TTC_RST_BYTE;
			mode01_r <= TTC_RST_BYTE;
			rl0l_r <= TTC_RST_BYTE; rl0h_r <= TTC_RST_BYTE;
			rl1l_r <= TTC_RST_BYTE; rl1h_r <= TTC_RST_BYTE;
			capl_r <= TTC_RST_BYTE; caph_r <= TTC_RST_BYTE; // RULE17
		end else begin
			if (wr_hit(bus_req_in, TTC_OFF_SYSCFG)) syscfg_r <= bus_req_in.wdata & TTC_SYSCFG_MASK;
			if (wr_hit(bus_req_in, TTC_OFF_MODE01)) mode01_r <= bus_req_in.wdata;
			if (wr_hit(bus_req_in, TTC_OFF_RL0L)) rl0l_r <= bus_req_in.wdata;
			if (wr_hit(bus_req_in, TTC_OFF_RL0H)) rl0h_r <= bus_req_in.wdata;
			if (wr_hit(bus_req_in, TTC_OFF_RL1L)) rl1l_r <= bus_req_in.wdata;
			if (wr_hit(bus_req_in, TTC_OFF_RL1H)) rl1h_r <= bus_req_in.wdata;
			if (wr_hit(bus_req_in, TTC_OFF_CAPL)) capl_r <= bus_req_in.wdata;
			if (wr_hit(bus_req_in, TTC_OFF_CAPH)) caph_r <= bus_req_in.wdata;
		end
	end
	// Count bytes; a software write takes priority over counting in that cycle
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			t0l_r <= TTC_RST_BYTE; t0h_r <= TTC_RST_BYTE;
			t1l_r <= TTC_RST_BYTE; t1h_r <= TTC_RST_BYTE;
			t2l_r <= TTC_RST_BYTE; t2h_r <= TTC_RST_BYTE;
		end else begin
			t0l_r <= wr_hit(bus_req_in, TTC_OFF_T0L) ? bus_req_in.wdata : n0l;
			t0h_r <= wr_hit(bus_req_in, TTC_OFF_T0H) ? bus_req_in.wdata : n0h;
			t1l_r <= wr_hit(bus_req_in, TTC_OFF_T1L) ? bus_req_in.wdata : n1l;
			t1h_r <= wr_hit(bus_req_in, TTC_OFF_T1H) ? bus_req_in.wdata : n1h;
			t2l_r <= wr_hit(bus_req_in, TTC_OFF_T2L) ? bus_req_in.wdata : n2[7:0];
			t2h_r <= wr_hit(bus_req_in, TTC_OFF_T2H) ? bus_req_in.wdata : n2[15:8];
		end
	end
	// ************************************************************
	// Read path: registered, upper byte fixed at zero
	// ************************************************************
	logic [7:0] rd_byte;
	logic [7:0] rd_src;
	always_comb begin
		rd_byte = 8'h00;
		rd_src = 8'h00;
		if      (bus_req_in.addr[11:3] == TTC_BIT_CTRL01[11:3])  rd_src = ctrl01_r;
		else if (bus_req_in.addr[11:3] == TTC_BIT_EXTSTAT[11:3]) rd_src = extstat_r;
		else if (bus_req_in.addr[11:3] == TTC_BIT_T2CTRL[11:3])  rd_src = t2ctrl_r;
		else if (bus_req_in.addr[11:3] == TTC_BIT_T2MODE[11:3])  rd_src = t2mode_r;
		if (bus_req_in.bit_op) rd_byte = {7'h00, rd_src[bus_req_in.addr[2:0]]};
		else if (bus_req_in.addr == TTC_OFF_CTRL01)  rd_byte = ctrl01_r;
		else if (bus_req_in.addr == TTC_OFF_EXTSTAT) rd_byte = extstat_r;
		else if (bus_req_in.addr == TTC_OFF_T2CTRL)  rd_byte = t2ctrl_r;
		else if (bus_req_in.addr == TTC_OFF_T2MODE)  rd_byte = t2mode_r;
		else if (bus_req_in.addr == TTC_OFF_SYSCFG)  rd_byte = syscfg_r;
		else if (bus_req_in.addr == TTC_OFF_T0L)     rd_byte = t0l_r; // RULE3
		else if (bus_req_in.addr == TTC_OFF_T0H)     rd_byte = t0h_r;
		else if (bus_req_in.addr == TTC_OFF_T1L)     rd_byte = t1l_r;
		else if (bus_req_in.addr == TTC_OFF_T1H)     rd_byte = t1h_r;
		else if (bus_req_in.addr == TTC_OFF_RL0L)    rd_byte = rl0l_r;
		else if (bus_req_in.addr == TTC_OFF_RL0H)    rd_byte = rl0h_r;
		else if (bus_req_in.addr == TTC_OFF_RL1L)    rd_byte = rl1l_r;
		else if (bus_req_in.addr == TTC_OFF_RL1H)    rd_byte = rl1h_r;
		else if (bus_req_in.addr == TTC_OFF_T2L)     rd_byte = t2l_r;
		else if (bus_req_in.addr == TTC_OFF_T2H)     rd_byte = t2h_r;
		else if (bus_req_in.addr == TTC_OFF_CAPL)    rd_byte = capl_r;
		else if (bus_req_in.addr == TTC_OFF_CAPH)    rd_byte = caph_r;
		else if (bus_req_in.addr == TTC_OFF_MODE01)  rd_byte = mode01_r;
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in)
			bus_rdata_out <= 16'h0000;
		else if (bus_req_in.rd)
			bus_rdata_out <= {8'h00, rd_byte}; // RULE18
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in)
			overflow_out <= 3'h0;
		else
			overflow_out <= {ovf2, set_tf1, set_tf0};
	end
	// ************************************************************
	// Checks
	// ************************************************************
	// Reload, hold and down-count behaviour of the count bytes, per mode
	sequence s_m0_wrap;
		inc0 && mode0 == TTC_M0_RELOAD16 && {t0h_r, t0l_r} == 16'hFFFF && !bus_req_in.wr;
	endsequence
	chk_mode0_reload: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE21
		s_m0_wrap |=> {t0h_r, t0l_r} == $past({rl0h_r, rl0l_r})) else $error("mode 0 reload wrong");
	chk_mode2_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE22
		inc0 && mode0 == TTC_M2_RELOAD8 && !bus_req_in.wr |=> t0h_r == $past(t0h_r)) else $error("mode 2 high changed");
	chk_t1_mode2_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE22
		inc1 && mode1 == TTC_M2_RELOAD8 && !bus_req_in.wr |=> t1h_r == $past(t1h_r)) else $error("t1 high changed");
	chk_t1_mode3: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE23
		mode1 == TTC_M3_SPLIT && !bus_req_in.wr |=> {t1h_r, t1l_r} == $past({t1h_r, t1l_r})) else $error("t1 moved");
	chk_t2_down: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE1
		inc2 && down2 && !bus_req_in.wr |=> {t2h_r, t2l_r} == $past({t2h_r, t2l_r}) - 16'h0001)
		else $error("t2 down step wrong");
	// Flags: the hardware set lands the cycle after the event, even against a clear
	chk_tf0_set: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE13
		set_tf0 |=> ctrl01_r[TTC_CTRL_TF0]) else $error("overflow flag lost");
	chk_tf1_set: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE13
		set_tf1 |=> ctrl01_r[TTC_CTRL_TF1]) else $error("t1 overflow flag lost");
	chk_t2_flag: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE15
		ovf2 && !t2mode_r[1] |=> t2ctrl_r[TTC_T2C_TF2]) else $error("t2 overflow flag lost");
	chk_ie1_level: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE13
		!ctrl01_r[2] && !int_s2_r[1] |=> ctrl01_r[3]) else $error("level interrupt flag lost");
	// Tick: a config write changes the spacing, so only quiet windows are judged
	sequence s_tick_quiet;
		tick && syscfg_r[3:2] == 2'd0 && !bus_req_in.wr ##1 (!bus_req_in.wr) [*3];
	endsequence
	chk_tick_rate: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE4
		s_tick_quiet |-> !tick && !$past(tick) && !$past(tick, 2) ##1 tick) else $error("tick not div 4");
	chk_tick_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE4
		tick |=> !tick) else $error("tick longer than one cycle");
	// Bus side: byte and bit writes land, reserved bits stay clear, upper byte fixed
	sequence s_run0_bit_wr;
		bus_req_in.wr && bus_req_in.bit_op && bus_req_in.addr == TTC_BIT_CTRL01 + 12'h004;
	endsequence
	chk_bit_write: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE20
		s_run0_bit_wr |=> ctrl01_r[TTC_CTRL_TR0] == $past(bus_req_in.wdata[0])) else $error("run bit write lost");
	chk_count_write: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE18
		wr_hit(bus_req_in, TTC_OFF_T0L) |=> t0l_r == $past(bus_req_in.wdata)) else $error("count byte write lost");
	chk_ext_mask: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE14
		(extstat_r & ~TTC_EXT_MASK) == 8'h00) else $error("ext status reserved set");
	chk_read_upper: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE18
		bus_rdata_out[15:8] == 8'h00) else $error("upper read byte nonzero");
	chk_no_inc_stop: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RULE2
		!t2ctrl_r[TTC_T2C_TR2] && !bus_req_in.wr |=> {t2h_r, t2l_r} == $past({t2h_r, t2l_r})) else $error("t2 ran stopped");
endmodule : ttc_unit

// ==== test/ttc_core_model.sv ====
// Purpose: Core model issuing byte accesses on the register port
// Assumes: One-cycle rd/wr pulses, read data one cycle later
// Notes:   Upper read byte is never trusted
module ttc_core_model
	import ttc_pkg::*;
(
	// Clock
	input  wire logic        sys_clk_in,
	// Register port
	input  wire logic [15:0] bus_rdata_in,
	output ttc_bus_req_t     bus_req_out
);
	timeunit 1ns;
	timeprecision 1ns;

	initial bus_req_out = '0;

	// One access; the strobe drops at the same edge that takes it
	task automatic access(input logic w, input logic b, input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		bus_req_out <= '{wr: w, rd: !w, bit_op: b, addr: a, wdata: d};
		@(posedge sys_clk_in);
		bus_req_out <= '0;
	endtask : access

	// Byte read; data is settled by the falling edge
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		access(1'b0, 1'b0, a, 8'h00);
		@(negedge sys_clk_in);
		d = bus_rdata_in[7:0];
	endtask : rd
endmodule : ttc_core_model

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the three timer/counter unit
// Assumes: Counter pins drive exact falling edges, so counts are exact
// Notes:   Timer mode is checked on timers 0 and 1 at divide-by-4
module tb_top
	import ttc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic         sys_clk_in = 1'b0;
	logic         rst_in     = 1'b1;
	ttc_bus_req_t bus_req;
	logic [15:0]  rdata;
	logic [2:0]   pins       = 3'h7;
	logic [1:0]   ints       = 2'h3;
	logic         tick;
	logic [2:0]   ovf;
	logic [7:0]   v;
	int           err_count  = 0;
	int           checks     = 0;
	int           cycles     = 0;
	int           ovf_n [3]  = '{0, 0, 0};

	// Overflow pulses stand one cycle; count them where they are settled
	always @(negedge sys_clk_in) begin
		for (int i = 0; i < 3; i++) begin
			if (ovf[i] === 1'b1) ovf_n[i]++;
		end
	end

	// 100 MHz oscillator
	always #5 sys_clk_in = ~sys_clk_in;

	ttc_unit DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_req_in(bus_req),
		.bus_rdata_out(rdata), .ext_count_in(pins), .ext_int_in(ints),
		.tick_out(tick), .overflow_out(ovf));
	ttc_core_model u_core (.sys_clk_in(sys_clk_in), .bus_rdata_in(rdata), .bus_req_out(bus_req));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	// A hang counts as a mismatch
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk8

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		u_core.access(1'b1, 1'b0, a, d);
	endtask : wr

	task automatic wbit(input logic [11:0] a, input logic b);
		u_core.access(1'b1, 1'b1, a, {7'h00, b});
	endtask : wbit

	task automatic rchk(input string n, input logic [11:0] a, input logic [7:0] e);
		u_core.rd(a, v);
		chk8(n, e, v);
	endtask : rchk

	// Fastest legal source: each level held 2 cycles, then time to detect
	task automatic pulse(input int i, input int n);
		repeat (n) begin
			repeat (2) @(posedge sys_clk_in);
			pins[i] <= 1'b0;
			repeat (2) @(posedge sys_clk_in);
			pins[i] <= 1'b1;
		end
		repeat (8) @(posedge sys_clk_in);
	endtask : pulse

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		logic [11:0] regs [13] = '{TTC_OFF_CTRL01, TTC_OFF_EXTSTAT, TTC_OFF_T2CTRL, TTC_OFF_T2MODE,
			TTC_OFF_T0L, TTC_OFF_T0H, TTC_OFF_T1L, TTC_OFF_T1H, TTC_OFF_T2L, TTC_OFF_T2H,
			TTC_OFF_CAPL, TTC_OFF_CAPH, TTC_OFF_MODE01};
		foreach (regs[k]) rchk("reset value", regs[k], 8'h00);
		wr(TTC_OFF_EXTSTAT, 8'hFF);
		rchk("ext status", TTC_OFF_EXTSTAT, 8'h05);
		wr(TTC_OFF_T2MODE, 8'hFF);
		rchk("t2 mode", TTC_OFF_T2MODE, 8'h33);
		wr(12'h4FF, 8'hA5);
		rchk("unmapped", 12'h4FF, 8'h00);
		wr(TTC_OFF_EXTSTAT, 8'h00);
		wr(TTC_OFF_T2MODE, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_tick();
		int n;
		for (int p = 0; p < 4; p++) begin
			wr(TTC_OFF_SYSCFG, 8'(p << 2));
			repeat (70) @(posedge sys_clk_in);
			n = 0;
			repeat (256) @(negedge sys_clk_in) if (tick === 1'b1) n++;
			chk8("tick pulses", p == 1 ? 8'h10 : p == 2 ? 8'h04 : 8'h40, 8'(n));
		end
		$display("test tick done");
	endtask : t_tick

	// Timer 0 counting pin edges in 16-bit reload mode
	task automatic t_mode0();
		wr(TTC_OFF_MODE01, 8'h04);
		wr(TTC_OFF_RL0L, 8'h34);
		wr(TTC_OFF_RL0H, 8'h12);
		wr(TTC_OFF_T0L, 8'hFF);
		wr(TTC_OFF_T0H, 8'hFF);
		wbit(TTC_BIT_CTRL01 + 12'h004, 1'b1);
		pulse(0, 1);
		rchk("t0 high", TTC_OFF_T0H, 8'h12);
		rchk("t0 low", TTC_OFF_T0L, 8'h34);
		rchk("ctrl", TTC_OFF_CTRL01, 8'h30);
		chk8("t0 overflow pulses", 8'h01, 8'(ovf_n[0]));
		pulse(0, 2);
		rchk("t0 low", TTC_OFF_T0L, 8'h36);
		wbit(TTC_BIT_CTRL01 + 12'h005, 1'b0);
		rchk("ctrl", TTC_OFF_CTRL01, 8'h10);
		wr(TTC_OFF_CTRL01, 8'h00);
		$display("test mode0 done");
	endtask : t_mode0

	// Timer 1 in 8-bit reload, then held in mode 3
	task automatic t_mode2();
		wr(TTC_OFF_MODE01, 8'h60);
		wr(TTC_OFF_RL1L, 8'hF0);
		wr(TTC_OFF_T1H, 8'h55);
		wr(TTC_OFF_T1L, 8'hFF);
		wbit(TTC_BIT_CTRL01 + 12'h006, 1'b1);
		pulse(1, 1);
		rchk("t1 low", TTC_OFF_T1L, 8'hF0);
		rchk("t1 high", TTC_OFF_T1H, 8'h55);
		rchk("ctrl", TTC_OFF_CTRL01, 8'hC0);
		chk8("t1 overflow pulses", 8'h01, 8'(ovf_n[1]));
		wr(TTC_OFF_MODE01, 8'h70);
		pulse(1, 3);
		rchk("t1 held", TTC_OFF_T1L, 8'hF0);
		wr(TTC_OFF_CTRL01, 8'h00);
		$display("test mode2 done");
	endtask : t_mode2

	// Timers 0 and 1 on the shared tick: 40 counted edges at divide-by-4 give 10
	task automatic t_timer();
		wr(TTC_OFF_SYSCFG, 8'h00);
		wr(TTC_OFF_MODE01, 8'h12);
		wr(TTC_OFF_T0L, 8'h00);
		wr(TTC_OFF_T0H, 8'h77);
		wr(TTC_OFF_T1L, 8'h00);
		wr(TTC_OFF_T1H, 8'h00);
		wr(TTC_OFF_CTRL01, 8'h50);
		repeat (38) @(posedge sys_clk_in);
		wr(TTC_OFF_CTRL01, 8'h00);
		rchk("t1 low", TTC_OFF_T1L, 8'h0A);
		rchk("t1 high", TTC_OFF_T1H, 8'h00);
		rchk("t0 low", TTC_OFF_T0L, 8'h0A);
		rchk("t0 high", TTC_OFF_T0H, 8'h77);
		$display("test timer done");
	endtask : t_timer

	// Timer 2 counting up across its wrap, then down across it again
	task automatic t_t2();
		wr(TTC_OFF_T2L, 8'hFA);
		wr(TTC_OFF_T2H, 8'hFF);
		wr(TTC_OFF_T2CTRL, 8'h06);
		pulse(2, 10);
		rchk("t2 low", TTC_OFF_T2L, 8'h04);
		rchk("t2 high", TTC_OFF_T2H, 8'h00);
		rchk("t2 ctrl", TTC_OFF_T2CTRL, 8'h86);
		chk8("t2 overflow pulses", 8'h01, 8'(ovf_n[2]));
		@(posedge sys_clk_in);
		ints[1] <= 1'b0;
		wr(TTC_OFF_T2MODE, 8'h01);
		pulse(2, 5);
		rchk("t2 low", TTC_OFF_T2L, 8'hFF);
		rchk("t2 high", TTC_OFF_T2H, 8'hFF);
		$display("test t2 done");
	endtask : t_t2

	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_tick();
		t_mode0();
		t_mode2();
		t_timer();
		t_t2();
		wrap_up();
	end
endmodule : tb_top
